// ==== logic/table_engine_defs.svh ====
`ifndef TABLE_ENGINE_DEFS_SVH
`define TABLE_ENGINE_DEFS_SVH

// offsets of the pointer word and of the first data word from the table base
`define PTR_OFS 16'h0001
`define DATA_OFS 16'h0002
// length limits of a define operation, in bcd
`define MIN_LEN 16'h0003
`define MAX_LEN 16'h9999
`define ZERO_WORD 16'h0000
`define ONE_WORD 16'h0001
`define BCD_DIGIT_MAX 4'h9
`define WORD_BITS 16
`define NIBBLES 4

`endif

// ==== logic/table_engine_pkg.sv ====
package table_engine_pkg;

   typedef enum logic [1:0]
   {
      define_table_op = 2'h0,
      push_word_op = 2'h1,
      pop_newest_op = 2'h2,
      pop_oldest_op = 2'h3
   } op_e;

   // command from the instruction sequencer
   typedef struct packed
   {
      op_e op;
      logic cond;
      logic indirect;
      logic bcd_mode;
      logic [15:0] table_base_word;
      logic [15:0] operand;
   } table_cmd_s;

   // host access to the data memory while the engine is idle
   typedef struct packed
   {
      logic write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_req_s;

endpackage

// ==== logic/word_fifo.sv ====
`timescale 1ns/1ps
module word_fifo
   import table_engine_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } fifo_state_s;

   logic [WIDTH-1:0] store [DEPTH];
   fifo_state_s s;
   fifo_state_s next_s;
   logic push;
   logic pop;

   // full is a count of DEPTH, which needs the extra count bit
   assign in_ready = (s.count != (AW+1)'(DEPTH));
   assign out_valid = (s.count != '0);
   assign out_data = store[s.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      next_s = s;
      if (push)
      begin
         next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + AW'(1);
      end
      if (pop)
      begin
         next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + AW'(1);
      end
      if (push && !pop)
      begin
         next_s.count = s.count + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
         next_s.count = s.count - (AW+1)'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   // storage has no reset; only words below count are ever shown
   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         store[s.wr] <= in_data;
      end
   end

endmodule

// ==== logic/word_table_stack_queue_engine.sv ====
`timescale 1ns/1ps
`include "table_engine_defs.svh"
module word_table_stack_queue_engine
   import table_engine_pkg::*;
#(
   parameter int ADDR_BITS = 12,
   parameter int RESULT_DEPTH = 32
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // commands from the sequencer
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire table_cmd_s cmd,
   output logic op_done,
   output logic instruction_error_flag,
   // destination words of the pop operations
   output logic res_valid,
   input wire logic res_ready,
   output logic [15:0] res_data,
   // host access to the data memory
   input wire logic mem_valid,
   output logic mem_ready,
   input wire mem_req_s mem_req,
   output logic mem_rvalid,
   output logic [15:0] mem_rdata
);

   localparam int WORDS = 2 ** ADDR_BITS;

   typedef enum logic [2:0]
   {
      st_idle = 3'h0,
      st_fetch = 3'h1,
      st_check = 3'h3,
      st_loop = 3'h2,
      st_ptr = 3'h6,
      st_done = 3'h7
   } state_e;

   typedef struct packed
   {
      state_e st;
      op_e op;
      logic bcd_mode;
      logic [15:0] base;
      logic [15:0] opnd;
      logic [15:0] ptr;
      logic [15:0] last;
      logic [15:0] idx;
      logic err;
      logic rvalid;
      logic [15:0] rdata;
   } engine_state_s;

   logic [15:0] dmem [WORDS];
   engine_state_s s;
   engine_state_s next_s;
   logic wr_en;
   logic [15:0] wr_addr;
   logic [15:0] wr_data;
   logic host_wr;
   logic fifo_valid;
   logic fifo_ready;
   logic [15:0] fifo_data;
   logic [15:0] ind_word;
   logic [15:0] ind_addr;
   logic [15:0] len_bin;
   logic [15:0] tbl_last;
   logic [15:0] tbl_ptr;
   logic [15:0] ptr_home;

   function automatic logic is_bcd(input logic [15:0] w);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < `NIBBLES; i++)
      begin
         if (w[4*i +: 4] > `BCD_DIGIT_MAX)
         begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   function automatic logic [15:0] bcd_to_bin(input logic [15:0] w);
      logic [15:0] v;
      v = '0;
      for (int i = `NIBBLES - 1; i >= 0; i--)
      begin
         v = 16'((v * 16'd10) + {12'h000, w[4*i +: 4]});
      end
      return v;
   endfunction

   // memory index of a 16-bit word address; upper bits wrap
   function automatic logic [ADDR_BITS-1:0] ix(input logic [15:0] a);
      return a[ADDR_BITS-1:0];
   endfunction

   assign ind_word = dmem[ix(s.opnd)];
   // an indirect word in bcd mode holds the operand address in bcd
   assign ind_addr = s.bcd_mode ? bcd_to_bin(ind_word) : ind_word;
   assign len_bin = bcd_to_bin(s.opnd);
   assign tbl_last = dmem[ix(s.base)];
   assign tbl_ptr = dmem[ix(s.base + `PTR_OFS)];
   assign ptr_home = s.base + `PTR_OFS;

   assign cmd_ready = (s.st == st_idle);
   // host waits while a command is offered so that the engine is never starved
   assign mem_ready = (s.st == st_idle) && !cmd_valid;
   assign host_wr = mem_valid && mem_ready && mem_req.write;
   assign op_done = (s.st == st_done);
   assign instruction_error_flag = s.err;
   assign mem_rvalid = s.rvalid;
   assign mem_rdata = s.rdata;

   always_comb
   begin
      next_s = s;
      next_s.rvalid = 1'b0;
      wr_en = 1'b0;
      wr_addr = `ZERO_WORD;
      wr_data = `ZERO_WORD;
      fifo_valid = 1'b0;
      fifo_data = `ZERO_WORD;
      case (s.st)
         st_idle:
         begin
            if (cmd_valid)
            begin
               // a false condition is answered without touching anything
               if (!cmd.cond)
               begin
                  next_s.st = st_done;
               end
               else
               begin
                  next_s.op = cmd.op;
                  next_s.bcd_mode = cmd.bcd_mode;
                  next_s.base = cmd.table_base_word;
                  next_s.opnd = cmd.operand;
                  next_s.err = 1'b0;
                  next_s.st = cmd.indirect ? st_fetch : st_check;
               end
            end
            else if (mem_valid && !mem_req.write)
            begin
               next_s.rvalid = 1'b1;
               next_s.rdata = dmem[ix(mem_req.addr)];
            end
         end
         st_fetch:
         begin
            if (s.bcd_mode && !is_bcd(ind_word))
            begin
               next_s.err = 1'b1;
               next_s.st = st_done;
            end
            else
            begin
               next_s.opnd = dmem[ix(ind_addr)];
               next_s.st = st_check;
            end
         end
         st_check:
         begin
            next_s.ptr = tbl_ptr;
            next_s.last = tbl_last;
            case (s.op)
               define_table_op:
               begin
                  if (!is_bcd(s.opnd) || s.opnd < `MIN_LEN)
                  begin
                     next_s.err = 1'b1;
                     next_s.st = st_done;
                  end
                  else
                  begin
                     // final-word address of the new table
                     wr_en = 1'b1;
                     wr_addr = s.base;
                     wr_data = s.base + len_bin - `ONE_WORD;
                     next_s.last = wr_data;
                     next_s.idx = s.base + `DATA_OFS;
                     next_s.st = st_ptr;
                  end
               end
               push_word_op:
               begin
                  if (tbl_ptr > tbl_last)
                  begin
                     next_s.err = 1'b1;
                     next_s.st = st_done;
                  end
                  else
                  begin
                     wr_en = 1'b1;
                     wr_addr = tbl_ptr;
                     wr_data = s.opnd;
                     next_s.st = st_ptr;
                  end
               end
               pop_newest_op:
               begin
                  if (tbl_ptr <= ptr_home)
                  begin
                     next_s.err = 1'b1;
                     next_s.st = st_done;
                  end
                  else
                  begin
                     // pointer written only once the result has room
                     fifo_valid = 1'b1;
                     fifo_data = dmem[ix(tbl_ptr - `ONE_WORD)];
                     if (fifo_ready)
                     begin
                        wr_en = 1'b1;
                        wr_addr = ptr_home;
                        wr_data = tbl_ptr - `ONE_WORD;
                        next_s.st = st_done;
                     end
                  end
               end
               default:
               begin
                  if (tbl_ptr <= ptr_home)
                  begin
                     next_s.err = 1'b1;
                     next_s.st = st_done;
                  end
                  else
                  begin
                     // oldest entry leaves before the shift overwrites it
                     fifo_valid = 1'b1;
                     fifo_data = dmem[ix(s.base + `DATA_OFS)];
                     if (fifo_ready)
                     begin
                        next_s.idx = s.base + `DATA_OFS;
                        next_s.st = st_loop;
                     end
                  end
               end
            endcase
         end
         st_ptr:
         begin
            wr_en = 1'b1;
            wr_addr = ptr_home;
            case (s.op)
               define_table_op:
               begin
                  wr_data = s.base + `DATA_OFS;
                  next_s.st = st_loop;
               end
               push_word_op:
               begin
                  wr_data = s.ptr + `ONE_WORD;
                  next_s.st = st_done;
               end
               default:
               begin
                  wr_data = s.ptr - `ONE_WORD;
                  next_s.st = st_done;
               end
            endcase
         end
         st_loop:
         begin
            wr_en = 1'b1;
            wr_addr = s.idx;
            next_s.idx = s.idx + `ONE_WORD;
            if (s.op == define_table_op)
            begin
               wr_data = `ZERO_WORD;
            end
            else
            begin
               // each word moves one address toward the head, last gets zero
               wr_data = (s.idx == s.last) ? `ZERO_WORD : dmem[ix(s.idx + `ONE_WORD)];
            end
            if (s.idx == s.last)
            begin
               next_s.st = (s.op == define_table_op) ? st_done : st_ptr;
            end
         end
         st_done:
         begin
            next_s.st = st_idle;
         end
         default:
         begin
            next_s.st = st_idle;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   // one write port, shared by engine and host; they never write together
   always_ff @(posedge sys_clk)
   begin
      if (wr_en)
      begin
         dmem[ix(wr_addr)] <= wr_data;
      end
      else if (host_wr)
      begin
         dmem[ix(mem_req.addr)] <= mem_req.wdata;
      end
   end

   // a full result buffer stalls pops, so a slow reader can never lose a word
   word_fifo #(
      .WIDTH(`WORD_BITS),
      .DEPTH(RESULT_DEPTH)
   ) result_fifo (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .in_valid(fifo_valid),
      .in_ready(fifo_ready),
      .in_data(fifo_data),
      .out_valid(res_valid),
      .out_ready(res_ready),
      .out_data(res_data)
   );

endmodule

// ==== test/table_engine_checker.sv ====
`timescale 1ns/1ps
module table_engine_checker
   import table_engine_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // command side
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire table_cmd_s cmd,
   input wire logic op_done,
   input wire logic instruction_error_flag,
   // result and memory sides
   input wire logic res_valid,
   input wire logic res_ready,
   input wire logic [15:0] res_data,
   input wire logic mem_valid,
   input wire logic mem_ready,
   input wire mem_req_s mem_req,
   input wire logic mem_rvalid
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   wire logic take = cmd_valid && cmd_ready && cmd.cond;
   wire logic [15:0] n = cmd.operand;
   wire logic bcd = n[15:12] < 4'ha && n[11:8] < 4'ha && n[7:4] < 4'ha && n[3:0] < 4'ha;
   sequence s_define_bad;
      take && cmd.op == define_table_op && !cmd.indirect && !(bcd && n >= 16'h0003);
   endsequence
   sequence s_error_end;
      ##[1:3] op_done ##[0:1] instruction_error_flag;
   endsequence
   AST_IDLE_COND:
   assert property (cmd_valid && cmd_ready && !cmd.cond |=>
         $stable(instruction_error_flag) throughout ##[0:1] op_done)
      else $error("false condition moved flag or gave no done");
   AST_BAD_LEN:
   assert property (s_define_bad |-> s_error_end)
      else $error("bad length not flagged");
   AST_FLAG_CLEAR:
   assert property (take |=> !instruction_error_flag)
      else $error("flag not cleared on take");
   AST_BUSY:
   assert property (take |=> !cmd_ready)
      else $error("ready while busy");
   AST_DONE_PULSE:
   assert property (op_done |=> !op_done)
      else $error("done longer than one cycle");
   AST_PUSH_TIME:
   assert property (take && cmd.op == push_word_op && !cmd.indirect |-> ##[1:5] op_done)
      else $error("push did not finish");
   AST_READ:
   assert property (mem_valid && mem_ready && !mem_req.write |=> mem_rvalid)
      else $error("read gave no data");
   AST_MEM_GUARD:
   assert property (cmd_valid |-> !mem_ready)
      else $error("memory open during command");
   AST_RES_HOLD:
   assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
      else $error("result dropped before taken");
   AST_FLAG_RISE:
   assert property ($rose(instruction_error_flag) |-> op_done || $past(op_done))
      else $error("flag rose outside completion");
endmodule
bind word_table_stack_queue_engine table_engine_checker chk_u (.sys_clk, .rst_b, .cmd_valid,
   .cmd_ready, .cmd, .op_done, .instruction_error_flag, .res_valid, .res_ready, .res_data,
   .mem_valid, .mem_ready, .mem_req, .mem_rvalid);

// ==== test/seq_model.sv ====
`timescale 1ns/1ps
module seq_model
   import table_engine_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // command port toward the engine
   output logic cmd_valid,
   input wire logic cmd_ready,
   output table_cmd_s cmd,
   input wire logic op_done
);
   int lost = 0;
   initial
   begin
      cmd_valid = 0;
      cmd = '0;
   end
   // one command in flight; callers name only tables they defined
   task automatic issue(input table_cmd_s c);
      int n = 0;
      @(posedge sys_clk);
      #1;
      cmd_valid = 1;
      cmd = c;
      while (cmd_ready !== 1'b1 && n++ < 50)
      begin
         @(posedge sys_clk);
         #1;
      end
      @(posedge sys_clk);
      #1;
      cmd_valid = 0;
      cmd = ~c;
      if (n > 50)
         lost++;
      n = 0;
      while (op_done !== 1'b1 && n++ < 5000)
      begin
         @(posedge sys_clk);
         #1;
      end
      if (n > 5000)
         lost++;
      @(posedge sys_clk);
      #1;
   endtask
endmodule

// ==== test/tb_word_table_stack_queue_engine.sv ====
`timescale 1ns/1ps
module tb_word_table_stack_queue_engine;
   import table_engine_pkg::*;
   localparam logic [15:0] B = 16'h0100;
   logic sys_clk = 0, rst_b = 0, mem_valid = 0, res_ready = 0, stall = 0, done_d = 0;
   logic cmd_valid, cmd_ready, op_done, instruction_error_flag;
   logic res_valid, mem_ready, mem_rvalid;
   logic [15:0] res_data, mem_rdata, d[3];
   table_cmd_s cmd;
   mem_req_s mem_req = '0;
   logic [15:0] exp_res[$], exp_mem[$], exp_flag[$];
   int bad_count = 0, check_count = 0;
   word_table_stack_queue_engine dut_u (.sys_clk, .rst_b, .cmd_valid, .cmd_ready, .cmd,
      .op_done, .instruction_error_flag, .res_valid, .res_ready, .res_data, .mem_valid,
      .mem_ready, .mem_req, .mem_rvalid, .mem_rdata);
   seq_model seq_u (.sys_clk, .cmd_valid, .cmd_ready, .cmd, .op_done);
   initial
      forever
         #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
      res_ready <= #1 stall ? 1'b0 : 1'($urandom);
   task automatic cmp(input logic [15:0] e, input logic [15:0] g, input string s);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, s, g, e);
      end
   endtask
   // a missing note shows up as an unknown expectation
   always @(posedge sys_clk)
   begin
      if (res_valid === 1'b1 && res_ready === 1'b1)
         cmp(exp_res.size() ? exp_res.pop_front() : 16'hxxxx, res_data, "result");
      if (mem_rvalid === 1'b1)
         cmp(exp_mem.size() ? exp_mem.pop_front() : 16'hxxxx, mem_rdata, "read");
      if (done_d)
         cmp(exp_flag.size() ? exp_flag.pop_front() : 16'hxxxx,
            {15'h0, instruction_error_flag}, "flag");
      done_d <= op_done === 1'b1;
   end
   task automatic end_of_test;
      bad_count += seq_u.lost + exp_res.size() + exp_mem.size() + exp_flag.size();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #200000;
      bad_count++;
      end_of_test;
   end
   task automatic mem_op(input logic w, input logic [15:0] a, input logic [15:0] v);
      int n = 0;
      @(posedge sys_clk);
      #1;
      mem_valid = 1;
      mem_req = '{w, a, v};
      while (mem_ready !== 1'b1 && n++ < 50)
      begin
         @(posedge sys_clk);
         #1;
      end
      if (n > 50)
         end_of_test;
      @(posedge sys_clk);
      #1;
      mem_valid = 0;
   endtask
   task automatic mr(input logic [15:0] a, input logic [15:0] e);
      exp_mem.push_back(e);
      mem_op(0, a, 16'h0);
   endtask
   task automatic run(input op_e o, input logic c, input logic [15:0] a,
      input logic [15:0] v, input logic e, input logic ind = 0);
      exp_flag.push_back({15'h0, e});
      seq_u.issue('{o, c, ind, ind, a, v});
   endtask
   initial
   begin
      void'($urandom(21644));
      repeat (8) @(posedge sys_clk);
      #1 rst_b = 1;
      for (int i = 0; i < 7; i++)
         mem_op(1, B + 16'(i), 16'hffff);
      run(define_table_op, 0, B, 16'h0007, 0);
      mr(B + 16'h2, 16'hffff);
      run(define_table_op, 1, B, 16'h0007, 0);
      mr(B, 16'h0106);
      mr(B + 16'h1, 16'h0102);
      for (int i = 2; i < 7; i++)
         mr(B + 16'(i), 16'h0);
      for (int i = 0; i < 3; i++)
      begin
         d[i] = 16'($urandom);
         run(push_word_op, 1, B, d[i], 0);
      end
      mr(B + 16'h1, 16'h0105);
      exp_res.push_back(d[2]);
      run(pop_newest_op, 1, B, 16'h0, 0);
      mr(B + 16'h1, 16'h0104);
      mr(B + 16'h4, d[2]);
      exp_res.push_back(d[0]);
      run(pop_oldest_op, 1, B, 16'h0, 0);
      mr(B + 16'h2, d[1]);
      mr(B + 16'h3, d[2]);
      mr(B + 16'h6, 16'h0);
      mr(B + 16'h1, 16'h0103);
      run(define_table_op, 1, 16'h0200, 16'h0002, 1);
      run(define_table_op, 1, 16'h0200, 16'h00a5, 1);
      run(push_word_op, 0, B, 16'h0, 1);
      mr(B + 16'h1, 16'h0103);
      mem_op(1, B + 16'h1, 16'h0101);
      run(pop_newest_op, 1, B, 16'h0, 1);
      run(pop_oldest_op, 1, B, 16'h0, 1);
      mr(B + 16'h2, d[1]);
      mem_op(1, B + 16'h1, 16'h0107);
      run(push_word_op, 1, B, 16'h1234, 1);
      mr(B + 16'h1, 16'h0107);
      mem_op(1, B + 16'h1, 16'h0106);
      run(push_word_op, 1, B, 16'h1234, 0);
      mr(B + 16'h6, 16'h1234);
      // room left in the table, so only the bad indirect word can raise the flag
      mem_op(1, B + 16'h1, 16'h0106);
      mem_op(1, 16'h0300, 16'h00ab);
      run(push_word_op, 1, B, 16'h0300, 1, 1);
      mr(B + 16'h1, 16'h0106);
      mem_op(1, 16'h0301, 16'h5a5a);
      mem_op(1, 16'h0300, 16'h0769);
      run(push_word_op, 1, B, 16'h0300, 0, 1);
      mr(B + 16'h6, 16'h5a5a);
      // reader held off so the result buffer fills and pops must wait
      stall = 1;
      run(define_table_op, 1, 16'h0400, 16'h0040, 0);
      for (int i = 0; i < 34; i++)
         run(push_word_op, 1, 16'h0400, 16'(i), 0);
      fork
         #2000 stall = 0;
      join_none
      for (int i = 33; i >= 0; i--)
      begin
         exp_res.push_back(16'(i));
         run(pop_newest_op, 1, 16'h0400, 16'h0, 0);
      end
      // a random reader needs about two cycles a word to drain the buffer
      for (int i = 0; i < 500 && exp_res.size() > 0; i++)
         @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      end_of_test;
   end
endmodule
